// ---- logic/drt_pkg.sv ----
// constants for the dual reload down timer: register map, fields, resets
// assumes a 16-bit register address and 4-bit data port
package drt_pkg;
  // ==========================================================
  // register offsets
  localparam logic [15:0] ADDR_EVCFG  = 16'hFFC0;
  localparam logic [15:0] ADDR_CKOUT  = 16'hFFC1;
  localparam logic [15:0] ADDR_T0CTL  = 16'hFFC2;
  localparam logic [15:0] ADDR_T1CTL  = 16'hFFC3;
  localparam logic [15:0] ADDR_T0RLL  = 16'hFFC4;
  localparam logic [15:0] ADDR_T0RLH  = 16'hFFC5;
  localparam logic [15:0] ADDR_T1RLL  = 16'hFFC6;
  localparam logic [15:0] ADDR_T1RLH  = 16'hFFC7;
  localparam logic [15:0] ADDR_T0CNL  = 16'hFFC8;
  localparam logic [15:0] ADDR_T0CNH  = 16'hFFC9;
  localparam logic [15:0] ADDR_T1CNL  = 16'hFFCA;
  localparam logic [15:0] ADDR_T1CNH  = 16'hFFCB;
  localparam logic [15:0] ADDR_IMASK  = 16'hFFE2;
  localparam logic [15:0] ADDR_IFLAG  = 16'hFFF2;
  // ==========================================================
  // field positions
  localparam int EV_POL    = 0;
  localparam int EV_FILT   = 1;
  localparam int EV_MODE   = 2;
  localparam int CK_SRC0   = 0;
  localparam int CK_SRC1   = 1;
  localparam int CK_OUTEN  = 2;
  localparam int CK_CHAN   = 3;
  localparam int CTL_RUN   = 0;
  localparam int CTL_PRST  = 1;
  localparam int CTL_RLO   = 2;
  // ==========================================================
  // reset values
  localparam logic [3:0] NIB_RST   = 4'h0;
  localparam logic [7:0] BYTE_RST  = 8'h00;
  // prescaler ratios as divide counts minus one
  localparam logic [7:0] DIV1_M1   = 8'h00;
  localparam logic [7:0] DIV4_M1   = 8'h03;
  localparam logic [7:0] DIV32_M1  = 8'h1F;
  localparam logic [7:0] DIV256_M1 = 8'hFF;
  // filter: edges of the 2,048 Hz signal needed to accept a level
  localparam logic [1:0] FILT_EDGES = 2'h2;
endpackage : drt_pkg

// ---- logic/drt_timer.sv ----
// two 8-bit reload down counters with prescalers, event input and clock out
// assumes oscillator and 2,048 Hz inputs are synchronous level signals
// ==========================================================
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
module drt_timer
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [3:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [3:0]  reg_rdata,
  // clock sources
  input  wire logic        slow_oscillator_clock,
  input  wire logic        fast_oscillator_clock,
  input  wire logic        ref_2048hz,
  // event input
  input  wire logic        event_input_pin,
  // outputs
  output logic             shared_output_pin,
  output logic      [1:0]  timer_irq
);
  // every check below runs on mclk and sleeps during reset
  default clocking chk_cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // decode
  wire wr_evcfg = reg_wr && reg_addr == drt_pkg::ADDR_EVCFG;
  wire wr_ckout = reg_wr && reg_addr == drt_pkg::ADDR_CKOUT;
  wire wr_imask = reg_wr && reg_addr == drt_pkg::ADDR_IMASK;
  wire wr_iflag = reg_wr && reg_addr == drt_pkg::ADDR_IFLAG;
  wire [1:0] wr_ctl;
  wire [1:0] wr_rll;
  wire [1:0] wr_rlh;
  wire [1:0] rd_cnl;
  assign wr_ctl[0] = reg_wr && reg_addr == drt_pkg::ADDR_T0CTL;
  assign wr_ctl[1] = reg_wr && reg_addr == drt_pkg::ADDR_T1CTL;
  assign wr_rll[0] = reg_wr && reg_addr == drt_pkg::ADDR_T0RLL;
  assign wr_rll[1] = reg_wr && reg_addr == drt_pkg::ADDR_T1RLL;
  assign wr_rlh[0] = reg_wr && reg_addr == drt_pkg::ADDR_T0RLH;
  assign wr_rlh[1] = reg_wr && reg_addr == drt_pkg::ADDR_T1RLH;
  assign rd_cnl[0] = reg_rd && reg_addr == drt_pkg::ADDR_T0CNL;
  assign rd_cnl[1] = reg_rd && reg_addr == drt_pkg::ADDR_T1CNL;

  // ==========================================================
  // configuration registers
  logic [2:0] evcfg_reg;
  logic [3:0] ckout_reg;
  logic [1:0] imask_reg;
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      evcfg_reg <= 3'h0;
      ckout_reg <= drt_pkg::NIB_RST;
      imask_reg <= 2'h0;
    end
    else
    begin
      if (wr_evcfg)
        evcfg_reg <= reg_wdata[2:0];
      if (wr_ckout)
        ckout_reg <= reg_wdata;
      if (wr_imask)
        imask_reg <= reg_wdata[1:0];
    end

  wire ev_mode = evcfg_reg[drt_pkg::EV_MODE];
  wire ev_filt = evcfg_reg[drt_pkg::EV_FILT];
  wire ev_pol  = evcfg_reg[drt_pkg::EV_POL];

  // ==========================================================
  // event input conditioning
  // the 2,048 Hz edge is found from its own previous sample
  logic ref_d_reg;
  logic ev_raw_reg;
  logic ev_filt_reg;
  logic [1:0] filt_cnt_reg;
  wire ref_fall = ref_d_reg && !ref_2048hz;
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      // event line idles high: no false edge after reset
      ref_d_reg    <= 1'b0;
      ev_raw_reg   <= 1'b1;
      ev_filt_reg  <= 1'b1;
      filt_cnt_reg <= 2'h0;
    end
    else
    begin
      ref_d_reg  <= ref_2048hz;
      ev_raw_reg <= event_input_pin;
      if (ev_raw_reg == ev_filt_reg)
        filt_cnt_reg <= 2'h0;
      else if (ref_fall)
      begin
        if (filt_cnt_reg == drt_pkg::FILT_EDGES - 2'h1)
        begin
          ev_filt_reg  <= ev_raw_reg;
          filt_cnt_reg <= 2'h0;
        end
        else
          filt_cnt_reg <= filt_cnt_reg + 2'h1;
      end
    end
  // filter off: raw sample feeds the counter directly
  wire ev_level = ev_filt ? ev_filt_reg : ev_raw_reg;
  logic ev_lvl_d_reg;
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      ev_lvl_d_reg <= 1'b1;
    else
      ev_lvl_d_reg <= ev_level;
  wire ev_rise = ev_level && !ev_lvl_d_reg;
  wire ev_fall = !ev_level && ev_lvl_d_reg;
  wire ev_tick = ev_pol ? ev_rise : ev_fall;

  // ==========================================================
  // per-timer logic
  logic [1:0] uflow;
  logic [1:0] run_rd;
  logic [1:0] iflag_reg;
  logic [7:0] cnt_rd  [2];
  logic [3:0] hold_rd [2];
  logic [3:0] ctl_rd  [2];
  logic [7:0] rl_rd   [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_tmr
      logic [3:0] ctl_reg;
      logic [7:0] rl_reg;
      logic [7:0] cnt_reg;
      logic [3:0] hold_reg;
      logic       act_reg;
      logic       src_d_reg;
      logic [7:0] pre_reg;
      wire  [1:0] ratio = ctl_reg[3:2];
      wire        src = ckout_reg[g] ? fast_oscillator_clock
                                     : slow_oscillator_clock;
      wire        src_rise = src && !src_d_reg;
      wire  [7:0] div_m1 = ratio == 2'h0 ? drt_pkg::DIV1_M1 :
                           ratio == 2'h1 ? drt_pkg::DIV4_M1 :
                           ratio == 2'h2 ? drt_pkg::DIV32_M1 :
                                           drt_pkg::DIV256_M1;
      wire        pre_tick = src_rise && pre_reg >= div_m1;
      // event mode bypasses source select and ratio of timer 0
      wire        in_tick = (g == 0 && ev_mode) ? ev_tick
                                                : pre_tick;
      wire        preset = wr_ctl[g] && reg_wdata[drt_pkg::CTL_PRST];
      wire        dec = act_reg && in_tick;
      wire        uf  = dec && cnt_reg == drt_pkg::BYTE_RST;
      always_ff @(posedge mclk or negedge arst_n)
        if (!arst_n)
        begin
          ctl_reg   <= drt_pkg::NIB_RST;
          rl_reg    <= drt_pkg::BYTE_RST;
          cnt_reg   <= drt_pkg::BYTE_RST;
          hold_reg  <= drt_pkg::NIB_RST;
          act_reg   <= 1'b0;
          src_d_reg <= 1'b0;
          pre_reg   <= drt_pkg::BYTE_RST;
        end
        else
        begin
          src_d_reg <= src;
          if (wr_ctl[g])
            ctl_reg <= {reg_wdata[3:2], 1'b0, reg_wdata[0]};
          if (wr_rll[g])
            rl_reg[3:0] <= reg_wdata;
          if (wr_rlh[g])
            rl_reg[7:4] <= reg_wdata;
          // prescaler runs while the timer requests run or is still active
          if (!ctl_reg[drt_pkg::CTL_RUN] && !act_reg)
            pre_reg <= drt_pkg::BYTE_RST;
          else if (src_rise)
            pre_reg <= pre_tick ? drt_pkg::BYTE_RST : pre_reg + 8'h01;
          if (in_tick)
            act_reg <= ctl_reg[drt_pkg::CTL_RUN];
          if (preset || uf)
            cnt_reg <= rl_reg;
          else if (dec)
            cnt_reg <= cnt_reg - 8'h01;
          if (rd_cnl[g])
            hold_reg <= cnt_reg[7:4];
        end
      assign uflow[g]   = uf;
      assign run_rd[g]  = ctl_reg[drt_pkg::CTL_RUN] | act_reg;
      assign cnt_rd[g]  = cnt_reg;
      assign hold_rd[g] = hold_reg;
      assign ctl_rd[g]  = ctl_reg;
      assign rl_rd[g]   = rl_reg;
    end
  endgenerate

  // ==========================================================
  // flags, clock out, interrupt request
  logic timer_clock_out_reg;
  wire  sel_uf = ckout_reg[drt_pkg::CK_CHAN] ? uflow[1] : uflow[0];
  wire [1:0] iflag_clr = wr_iflag ? reg_wdata[1:0] : 2'h0;
  wire [1:0] iflag_next = uflow | (iflag_reg & ~iflag_clr);
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      iflag_reg         <= 2'h0;
      timer_clock_out_reg          <= 1'b0;
      shared_output_pin <= 1'b1;
      timer_irq         <= 2'h0;
    end
    else
    begin
      iflag_reg <= iflag_next;
      if (sel_uf)
        timer_clock_out_reg <= !timer_clock_out_reg;
      // pin is high while clock-out is off
      shared_output_pin <= ckout_reg[drt_pkg::CK_OUTEN] ? timer_clock_out_reg
                                                        : 1'b1;
      timer_irq <= iflag_next & imask_reg;
    end

  // ==========================================================
  // read mux, data one cycle after the strobe
  logic [3:0] rdata_next;
  always_comb
  begin
    rdata_next = drt_pkg::NIB_RST;
    unique case (reg_addr)
      drt_pkg::ADDR_EVCFG: rdata_next = {1'b0, evcfg_reg};
      drt_pkg::ADDR_CKOUT: rdata_next = ckout_reg;
      drt_pkg::ADDR_T0CTL: rdata_next = {ctl_rd[0][3:2], 1'b0, run_rd[0]};
      drt_pkg::ADDR_T1CTL: rdata_next = {ctl_rd[1][3:2], 1'b0, run_rd[1]};
      drt_pkg::ADDR_T0RLL: rdata_next = rl_rd[0][3:0];
      drt_pkg::ADDR_T0RLH: rdata_next = rl_rd[0][7:4];
      drt_pkg::ADDR_T1RLL: rdata_next = rl_rd[1][3:0];
      drt_pkg::ADDR_T1RLH: rdata_next = rl_rd[1][7:4];
      drt_pkg::ADDR_T0CNL: rdata_next = cnt_rd[0][3:0];
      drt_pkg::ADDR_T0CNH: rdata_next = hold_rd[0];
      drt_pkg::ADDR_T1CNL: rdata_next = cnt_rd[1][3:0];
      drt_pkg::ADDR_T1CNH: rdata_next = hold_rd[1];
      drt_pkg::ADDR_IMASK: rdata_next = {2'h0, imask_reg};
      drt_pkg::ADDR_IFLAG: rdata_next = {2'h0, iflag_reg};
      default:             rdata_next = drt_pkg::NIB_RST;
    endcase
  end
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      reg_rdata <= drt_pkg::NIB_RST;
    else
      reg_rdata <= reg_rd ? rdata_next : drt_pkg::NIB_RST;

  // ==========================================================
  // checks
  flag_set_a: assert property (
    uflow[0] |=> iflag_reg[0])
    else $error("t0 flag not set by underflow");
  flag1_set_a: assert property (
    uflow[1] |=> iflag_reg[1])
    else $error("t1 flag not set by underflow");
  flag_clear_a: assert property (
    wr_iflag && reg_wdata[1] && !uflow[1] |=> !iflag_reg[1])
    else $error("t1 flag not cleared");
  flag0_clear_a: assert property (
    wr_iflag && reg_wdata[0] && !uflow[0] |=> !iflag_reg[0])
    else $error("t0 flag not cleared");
  irq_gate_a: assert property (
    ##1 timer_irq[0] == $past(iflag_next[0] & imask_reg[0]))
    else $error("t0 irq not flag and mask");
  irq1_gate_a: assert property (
    ##1 timer_irq[1] == $past(iflag_next[1] & imask_reg[1]))
    else $error("t1 irq not flag and mask");
  irq_masked_a: assert property (
    !imask_reg[0] |=> !timer_irq[0])
    else $error("t0 irq seen while masked");
  irq1_masked_a: assert property (
    !imask_reg[1] |=> !timer_irq[1])
    else $error("t1 irq seen while masked");
  timer_clock_out_toggle_a: assert property (
    sel_uf |=> timer_clock_out_reg != $past(timer_clock_out_reg))
    else $error("clock-out did not toggle");
  pin_high_a: assert property (
    !ckout_reg[drt_pkg::CK_OUTEN] |=> shared_output_pin)
    else $error("pin not high while disabled");
  pin_follow_a: assert property (
    ckout_reg[drt_pkg::CK_OUTEN] |=> shared_output_pin == $past(timer_clock_out_reg))
    else $error("pin does not follow clock-out");
  reload_uf_a: assert property (
    uflow[1] |=> cnt_rd[1] == $past(rl_rd[1]))
    else $error("t1 not reloaded on underflow");
  reload_t0_a: assert property (
    uflow[0] |=> cnt_rd[0] == $past(rl_rd[0]))
    else $error("t0 not reloaded on underflow");
  preset_load_a: assert property (
    g_tmr[0].preset |=> cnt_rd[0] == $past(rl_rd[0]))
    else $error("t0 preset did not load reload value");
  stop_hold_a: assert property (
    !run_rd[1] && !g_tmr[1].preset |=> cnt_rd[1] == $past(cnt_rd[1]))
    else $error("t1 count moved while stopped");
  event_only_a: assert property (
    ev_mode && !ev_tick && !g_tmr[0].preset
    |=> cnt_rd[0] == $past(cnt_rd[0]))
    else $error("t0 counted without an event edge");
  hold_hi_a: assert property (
    rd_cnl[0] |=> hold_rd[0] == $past(cnt_rd[0][7:4]))
    else $error("high nibble not held");
  strobe_zero_a: assert property (
    reg_rd && reg_addr == drt_pkg::ADDR_T0CTL |=> !reg_rdata[1])
    else $error("preset strobe read nonzero");
  unused_zero_a: assert property (
    reg_rd && reg_addr == drt_pkg::ADDR_IFLAG |=> reg_rdata[3:2] == 2'h0)
    else $error("unused flag bits read nonzero");
  filt_edge_a: assert property (
    $changed(ev_filt_reg) |-> $past(ref_fall))
    else $error("filter moved off a reference edge");
endmodule : drt_timer

// ---- verif/drt_far_side.sv ----
// far side model: event pulse source and clock-out consumer
// assumes the bench calls its tasks from a clock-synchronous flow
`timescale 1ns/1ns
module drt_far_side
(
  // clock
  input  wire logic mclk,
  // lines
  input  wire logic shared_output_pin,
  output logic      event_input_pin
);
  int   toggle_count;
  logic pin_q;
  initial
  begin
    event_input_pin = 1'b1;
    toggle_count = 0;
    pin_q = 1'b1;
  end
  // ==========================================================
  // consumer, pin driven and never floated; counts each change from its last sample
  always @(posedge mclk)
  begin
    if (shared_output_pin !== pin_q)
      toggle_count++;
    pin_q <= shared_output_pin;
  end
  // ==========================================================
  // source: event line idles high
  task automatic level(input logic v, input int w);
    @(posedge mclk);
    event_input_pin <= v;
    repeat (w) @(posedge mclk);
  endtask : level
  task automatic pulse(input int w);
    level(1'b0, w);
    level(1'b1, w);
  endtask : pulse
endmodule : drt_far_side

// ---- verif/drt_timer_tb.sv ----
// self-checking bench for the dual reload down timer
// assumes drt_far_side drives the event line and watches clock-out
`timescale 1ns/1ns
module drt_timer_tb;
  // ==========================================================
  // signals
  logic        mclk;
  logic        arst_n;
  logic [15:0] reg_addr;
  logic [3:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [3:0]  reg_rdata;
  logic [7:0]  cyc;
  logic        ev_pin;
  logic        out_pin;
  logic [1:0]  irq;
  logic [7:0]  c;
  wire         slow_clk;
  wire         fast_clk;
  wire         ref_clk;
  int          num_errors;
  int          checked;
  int          n0;
  int          d;
  int          ex [5] = '{32, 128, 32, 4, 0};
  drt_timer dut
  (
    .mclk                  (mclk),
    .arst_n                (arst_n),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_rdata             (reg_rdata),
    .slow_oscillator_clock (slow_clk),
    .fast_oscillator_clock (fast_clk),
    .ref_2048hz            (ref_clk),
    .event_input_pin       (ev_pin),
    .shared_output_pin     (out_pin),
    .timer_irq             (irq)
  );
  drt_far_side far
  (
    .mclk              (mclk),
    .shared_output_pin (out_pin),
    .event_input_pin   (ev_pin)
  );
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // sources: slow period 16, fast period 4 mclk
  always @(posedge mclk)
    cyc <= cyc + 8'h01;
  assign slow_clk = cyc[3];
  assign fast_clk = cyc[1];
  assign ref_clk  = cyc[3];
  // ==========================================================
  // tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [3:0] v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [3:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
  task automatic chk(input logic [15:0] a, input logic [3:0] e);
    logic [3:0] v;
    rd(a, v);
    check({4'h0, v}, {4'h0, e});
  endtask : chk
  // low nibble first so the high nibble is the frozen one
  task automatic cnt(input logic [15:0] a, output logic [7:0] v);
    rd(a, v[3:0]);
    rd(a + 16'h0001, v[7:4]);
  endtask : cnt
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    finish_test();
  end
  // ==========================================================
  // tests
  initial
  begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cyc = 8'h00;
    num_errors = 0;
    checked = 0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    check({7'h00, out_pin}, 8'h01);
    check({6'h00, irq}, 8'h00);
    for (int i = 0; i < 12; i++)
      chk(16'hFFC0 + 16'(i), 4'h0);
    chk(16'hFFE2, 4'h0);
    chk(16'hFFF2, 4'h0);
    $display("test reset done");
    wr(16'hFFC0, 4'hF);
    chk(16'hFFC0, 4'h7);
    wr(16'hFFC7, 4'h5);
    chk(16'hFFC7, 4'h5);
    wr(16'hFFC9, 4'hF);
    chk(16'hFFC9, 4'h0);
    wr(16'hFFE2, 4'hF);
    chk(16'hFFE2, 4'h3);
    wr(16'hFFD0, 4'hF);
    chk(16'hFFD0, 4'h0);
    wr(16'hFFE2, 4'h0);
    wr(16'hFFC7, 4'h0);
    $display("test registers done");
    // event mode with fast source and /256 set, which must not matter
    wr(16'hFFC1, 4'h1);
    wr(16'hFFC0, 4'h4);
    wr(16'hFFC5, 4'h1);
    wr(16'hFFC2, 4'hF);
    chk(16'hFFC2, 4'hD);
    far.pulse(4);
    wr(16'hFFC2, 4'hF);
    chk(16'hFFC8, 4'h0);
    far.pulse(4);
    chk(16'hFFC9, 4'h1);
    far.pulse(4);
    far.pulse(4);
    cnt(16'hFFC8, c);
    check(c, 8'h0D);
    wr(16'hFFC2, 4'hC);
    chk(16'hFFC2, 4'hD);
    far.pulse(4);
    chk(16'hFFC2, 4'hC);
    wr(16'hFFC2, 4'hE);
    far.pulse(4);
    cnt(16'hFFC8, c);
    check(c, 8'h10);
    wr(16'hFFC4, 4'h2);
    wr(16'hFFC5, 4'h0);
    wr(16'hFFC2, 4'hD);
    far.pulse(4);
    wr(16'hFFC2, 4'hF);
    wr(16'hFFE2, 4'h1);
    repeat (3) far.pulse(4);
    cnt(16'hFFC8, c);
    check(c, 8'h02);
    chk(16'hFFF2, 4'h1);
    check({6'h00, irq}, 8'h01);
    wr(16'hFFF2, 4'h0);
    chk(16'hFFF2, 4'h1);
    wr(16'hFFF2, 4'h1);
    chk(16'hFFF2, 4'h0);
    check({6'h00, irq}, 8'h00);
    wr(16'hFFE2, 4'h0);
    wr(16'hFFC0, 4'h5);
    wr(16'hFFC2, 4'hF);
    far.level(1'b0, 8);
    cnt(16'hFFC8, c);
    check(c, 8'h02);
    far.level(1'b1, 8);
    cnt(16'hFFC8, c);
    check(c, 8'h01);
    wr(16'hFFC0, 4'h7);
    wr(16'hFFC2, 4'hF);
    far.pulse(1);
    repeat (40) @(posedge mclk);
    cnt(16'hFFC8, c);
    check(c, 8'h02);
    far.pulse(40);
    cnt(16'hFFC8, c);
    check(c, 8'h01);
    $display("test events done");
    // ratios never fall, so the prescaler never has to wrap
    wr(16'hFFC6, 4'hF);
    wr(16'hFFC7, 4'hF);
    wr(16'hFFC3, 4'h1);
    repeat (40) @(posedge mclk);
    for (int i = 0; i < 5; i++)
    begin
      wr(16'hFFC1, (i > 0) ? 4'h3 : 4'h1);
      wr(16'hFFC3, {2'((i < 2) ? 0 : i - 1), 2'b11});
      repeat (512) @(posedge mclk);
      cnt(16'hFFCA, c);
      d = 255 - int'(c);
      check(8'((d + 2 >= ex[i]) && (d <= ex[i] + 2)), 8'h01);
    end
    $display("test prescaler done");
    wr(16'hFFC6, 4'h3);
    wr(16'hFFC7, 4'h0);
    wr(16'hFFC3, 4'h3);
    wr(16'hFFC1, 4'h3);
    repeat (1100) @(posedge mclk);
    n0 = far.toggle_count;
    repeat (200) @(posedge mclk);
    check(8'(far.toggle_count - n0), 8'h00);
    check({7'h00, out_pin}, 8'h01);
    wr(16'hFFC1, 4'hF);
    n0 = far.toggle_count;
    repeat (320) @(posedge mclk);
    d = far.toggle_count - n0;
    check(8'(d >= 19 && d <= 21), 8'h01);
    wr(16'hFFC1, 4'h7);
    n0 = far.toggle_count;
    repeat (320) @(posedge mclk);
    check(8'(far.toggle_count - n0), 8'h00);
    chk(16'hFFF2, 4'h2);
    check({6'h00, irq}, 8'h00);
    wr(16'hFFE2, 4'h2);
    repeat (3) @(posedge mclk);
    check({6'h00, irq}, 8'h02);
    wr(16'hFFC3, 4'h0);
    repeat (8) @(posedge mclk);
    chk(16'hFFC3, 4'h0);
    wr(16'hFFF2, 4'h2);
    chk(16'hFFF2, 4'h0);
    check({6'h00, irq}, 8'h00);
    $display("test clock out done");
    // reset in mid-run must bring every register back
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    check({7'h00, out_pin}, 8'h01);
    check({6'h00, irq}, 8'h00);
    for (int i = 0; i < 12; i++)
      chk(16'hFFC0 + 16'(i), 4'h0);
    chk(16'hFFE2, 4'h0);
    chk(16'hFFF2, 4'h0);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule : drt_timer_tb
